/* File: common/ntc_pkg.sv */
package ntc_pkg;
  localparam int NTC_TIME_W        = 48;
  localparam int NTC_CLK_MHZ       = 40;
  localparam int NTC_REQ_DELAY_US  = 2000;
  localparam int NTC_REQ_DELAY_CYC = NTC_REQ_DELAY_US * NTC_CLK_MHZ;
  localparam int NTC_IDLE_US       = 100;
  localparam int NTC_IDLE_CYC      = NTC_IDLE_US * NTC_CLK_MHZ;
  localparam int NTC_PIN_STROBE    = 0;
  localparam int NTC_PIN_HOST_RX   = 1;
  localparam int NTC_PIN_CON_RX    = 2;
  localparam int NTC_PIN_RESTART   = 3;
  localparam int NTC_PIN_HOLD      = 4;
  localparam int NTC_PIN_N         = 5;
  localparam logic [NTC_PIN_N-1:0] NTC_PIN_RST = 5'h0f;
  localparam logic [NTC_TIME_W-1:0] NTC_TIME_RST = 48'h0;

  typedef enum logic {
    NTC_SRC_REQUEST,
    NTC_SRC_STROBE
  } ntc_src_t;

  typedef enum logic [1:0] {
    NTC_ST_BOOT,
    NTC_ST_ACTIVE,
    NTC_ST_DOZE
  } ntc_state_t;

  typedef struct packed {
    ntc_src_t                src;
    logic [NTC_TIME_W-1:0]   stamp;
  } ntc_pkt_t;

  typedef struct packed {
    logic periph_clk_en;
    logic lf_osc_en;
    logic ref_osc_en;
    logic dcdc_en;
    logic host_wake;
    logic console_wake;
  } ntc_pwr_t;
endpackage : ntc_pkg

/* File: design/ntc_network_time_capture.sv */
`timescale 1ns/1ps
module ntc_network_time_capture
  import ntc_pkg::*;
#(
  parameter int REQ_DELAY_CYC = NTC_REQ_DELAY_CYC
)(
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  input  wire logic                  time_strobe_n,
  input  wire logic                  board_restart_n,
  input  wire logic                  host_serial_rx,
  input  wire logic                  console_serial_rx,
  input  wire logic                  radio_hold_off,
  input  wire logic                  host_serial_busy,
  input  wire logic                  console_serial_busy,
  input  wire logic                  read_time_req,
  input  wire logic                  time_set_valid,
  input  wire logic [NTC_TIME_W-1:0] time_set_value,
  input  wire logic                  lf_osc_running,
  input  wire logic                  radio_needs_ref,
  input  wire logic                  cpu_busy,
  output logic                       pkt_valid,
  input  wire logic                  pkt_ready,
  output ntc_pkt_t                   pkt,
  output logic                       capture_overrun,
  output logic                       cpu_reboot,
  output ntc_pwr_t                   pwr
);

  localparam int DW = $clog2(REQ_DELAY_CYC + 1);
  localparam int IW = $clog2(NTC_IDLE_CYC + 1);
  localparam logic [DW-1:0] REQ_LAST = DW'(REQ_DELAY_CYC - 1);
  localparam logic [IW-1:0] IDLE_LAST = IW'(NTC_IDLE_CYC - 1);

  // pin synchronisers
  logic [NTC_PIN_N-1:0] pin_s1;
  logic [NTC_PIN_N-1:0] pin_s2;
  logic                 strobe_q;
  logic [NTC_PIN_N-1:0] next_pin_s1;
  logic [NTC_PIN_N-1:0] next_pin_s2;
  logic                 next_strobe_q;

  logic                 lrst;
  logic                 strobe_rise;
  logic                 hold_off;

  always_comb
  begin
    next_pin_s1   = {radio_hold_off, board_restart_n, console_serial_rx,
                     host_serial_rx, time_strobe_n};
    next_pin_s2   = pin_s1;
    next_strobe_q = pin_s2[NTC_PIN_STROBE];
  end

  // restart pin acts through its synchroniser, never raw
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      pin_s1   <= NTC_PIN_RST;
      pin_s2   <= NTC_PIN_RST;
      strobe_q <= 1'b1;
    end
    else
    begin
      pin_s1   <= next_pin_s1;
      pin_s2   <= next_pin_s2;
      strobe_q <= next_strobe_q;
    end
  end

  assign lrst        = !rst_b || !pin_s2[NTC_PIN_RESTART];
  assign strobe_rise = pin_s2[NTC_PIN_STROBE] && !strobe_q;
  assign hold_off    = pin_s2[NTC_PIN_HOLD];

  // network time, request delay and capture slot
  logic [NTC_TIME_W-1:0] now;
  logic [DW-1:0]         req_cnt;
  logic                  req_wait;
  logic                  pend;
  ntc_pkt_t              slot;
  logic                  overrun;
  logic [NTC_TIME_W-1:0] next_now;
  logic [DW-1:0]         next_req_cnt;
  logic                  next_req_wait;
  logic                  next_pend;
  ntc_pkt_t              next_slot;
  logic                  next_overrun;
  logic                  req_fire;
  logic                  cap_evt;
  logic                  taken;

  assign taken = pend && pkt_ready;

  always_comb
  begin
    next_now      = time_set_valid ? time_set_value : now + 1'b1;
    next_req_cnt  = req_cnt;
    next_req_wait = req_wait;
    next_pend     = pend;
    next_slot     = slot;
    next_overrun  = overrun;
    req_fire      = 1'b0;
    if (req_wait)
    begin
      if (req_cnt == REQ_LAST)
      begin
        req_fire = !strobe_rise;
      end
      else
      begin
        next_req_cnt = req_cnt + 1'b1;
      end
    end
    if (req_fire)
    begin
      next_req_wait = 1'b0;
      next_req_cnt  = '0;
    end
    if (read_time_req && !req_wait)
    begin
      next_req_wait = 1'b1;
      next_req_cnt  = '0;
    end
    cap_evt = strobe_rise || req_fire;
    if (taken)
    begin
      next_pend = 1'b0;
    end
    if (cap_evt)
    begin
      next_pend       = 1'b1;
      next_slot.stamp = now;
      next_slot.src   = strobe_rise ? NTC_SRC_STROBE : NTC_SRC_REQUEST;
      if (pend && !taken)
      begin
        next_overrun = 1'b1;
      end
    end
    else if (taken)
    begin
      next_overrun = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (lrst)
    begin
      now      <= NTC_TIME_RST;
      req_cnt  <= '0;
      req_wait <= 1'b0;
      pend     <= 1'b0;
      slot     <= '0;
      overrun  <= 1'b0;
    end
    else
    begin
      now      <= next_now;
      req_cnt  <= next_req_cnt;
      req_wait <= next_req_wait;
      pend     <= next_pend;
      slot     <= next_slot;
      overrun  <= next_overrun;
    end
  end

  assign pkt_valid       = pend;
  assign pkt             = slot;
  assign capture_overrun = overrun;

  // power state and clock sources
  ntc_state_t    state;
  logic [IW-1:0] idle_cnt;
  logic          lf_started;
  ntc_pwr_t      pwr_q;
  logic          reboot_q;
  ntc_state_t    next_state;
  logic [IW-1:0] next_idle_cnt;
  logic          next_lf_started;
  ntc_pwr_t      next_pwr;
  logic          host_act;
  logic          con_act;
  logic          busy;

  always_comb
  begin
    host_act = !pin_s2[NTC_PIN_HOST_RX] || host_serial_busy;
    con_act  = !pin_s2[NTC_PIN_CON_RX] || console_serial_busy;
    busy     = host_act || con_act || pend || req_wait || cpu_busy
               || radio_needs_ref || strobe_rise || read_time_req;
    next_state      = state;
    next_idle_cnt   = idle_cnt;
    next_lf_started = lf_started || lf_osc_running;
    case (state)
      NTC_ST_BOOT:
      begin
        next_state    = NTC_ST_ACTIVE;
        next_idle_cnt = '0;
      end
      NTC_ST_ACTIVE:
      begin
        if (busy || !lf_started)
        begin
          next_idle_cnt = '0;
        end
        else if (idle_cnt == IDLE_LAST)
        begin
          next_state    = NTC_ST_DOZE;
          next_idle_cnt = '0;
        end
        else
        begin
          next_idle_cnt = idle_cnt + 1'b1;
        end
      end
      NTC_ST_DOZE:
      begin
        if (busy)
        begin
          next_state = NTC_ST_ACTIVE;
        end
      end
      default:
      begin
        next_state    = NTC_ST_BOOT;
        next_idle_cnt = '0;
      end
    endcase
    next_pwr.periph_clk_en = (next_state != NTC_ST_DOZE);
    next_pwr.lf_osc_en     = 1'b1;
    next_pwr.ref_osc_en    = radio_needs_ref && !hold_off
                             && (next_state == NTC_ST_ACTIVE);
    next_pwr.dcdc_en       = (next_state != NTC_ST_DOZE);
    next_pwr.host_wake     = host_act;
    next_pwr.console_wake  = con_act;
  end

  always_ff @(posedge core_clk)
  begin
    if (lrst)
    begin
      state      <= NTC_ST_BOOT;
      idle_cnt   <= '0;
      lf_started <= 1'b0;
      pwr_q      <= '0;
    end
    else
    begin
      state      <= next_state;
      idle_cnt   <= next_idle_cnt;
      lf_started <= next_lf_started;
      pwr_q      <= next_pwr;
    end
  end

  // reboot flag follows the synchronised restart pin
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      reboot_q <= 1'b0;
    end
    else
    begin
      reboot_q <= !pin_s2[NTC_PIN_RESTART];
    end
  end

  assign pwr        = pwr_q;
  assign cpu_reboot = reboot_q;

endmodule : ntc_network_time_capture

/* File: tb/ntc_assertions.sv */
`timescale 1ns/1ps
module ntc_assertions
  import ntc_pkg::*;
#(
  parameter int REQ_DELAY_CYC = 8
)(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic time_strobe_n,
  input wire logic board_restart_n,
  input wire logic host_serial_rx,
  input wire logic radio_hold_off,
  input wire logic read_time_req,
  input wire logic radio_needs_ref,
  input wire logic pkt_valid,
  input wire logic pkt_ready,
  input ntc_pkt_t  pkt,
  input wire logic capture_overrun,
  input wire logic cpu_reboot,
  input ntc_pwr_t  pwr
);
  localparam int DP = REQ_DELAY_CYC + 1;
  localparam int DQ = REQ_DELAY_CYC + 2;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b || cpu_reboot || !board_restart_n);
  property p_strobe;
    $rose(time_strobe_n) |-> ##[1:4] (pkt_valid && pkt.src == NTC_SRC_STROBE);
  endproperty
  a_strobe: assert property (p_strobe) else $error("no strobe pkt");
  property p_req;
    $rose(pkt_valid) && pkt.src == NTC_SRC_REQUEST
      |-> $past(read_time_req, DP) || $past(read_time_req, DQ);
  endproperty
  a_req: assert property (p_req) else $error("request timing");
  property p_take;
    $stable(time_strobe_n) [*3] ##0 (pkt_valid && pkt_ready) |=> !pkt_valid;
  endproperty
  a_take: assert property (p_take) else $error("pkt not taken");
  property p_stand;
    pkt_valid && !pkt_ready |=> pkt_valid && ($stable(pkt) || capture_overrun);
  endproperty
  a_stand: assert property (p_stand) else $error("pkt dropped");
  property p_ovr;
    $rose(capture_overrun) |-> $past(pkt_valid);
  endproperty
  a_ovr: assert property (p_ovr) else $error("bad overrun");
  property p_ref;
    pwr.ref_osc_en |-> $past(radio_needs_ref);
  endproperty
  a_ref: assert property (p_ref) else $error("ref unneeded");
  property p_hold;
    radio_hold_off [*4] |=> !pwr.ref_osc_en;
  endproperty
  a_hold: assert property (p_hold) else $error("ref on hold");
  property p_lf;
    $past(pwr.lf_osc_en) |-> pwr.lf_osc_en;
  endproperty
  a_lf: assert property (p_lf) else $error("lf stopped");
  property p_wake;
    $fell(host_serial_rx) |-> ##[1:6] pwr.dcdc_en;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_boot;
    @(posedge core_clk) disable iff (!rst_b) !board_restart_n [*5] |-> cpu_reboot;
  endproperty
  a_boot: assert property (p_boot) else $error("no reboot");
  c_strobe: cover property ($rose(pkt_valid) && pkt.src == NTC_SRC_STROBE);
  c_req: cover property ($rose(pkt_valid) && pkt.src == NTC_SRC_REQUEST);
  c_ovr: cover property ($rose(capture_overrun));
endmodule : ntc_assertions

/* File: tb/ntc_host_model.sv */
`timescale 1ns/1ps
module ntc_host_model
  import ntc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic stall,
  input  wire logic pkt_valid,
  input  ntc_pkt_t  pkt,
  output logic      pkt_ready
);
  ntc_pkt_t rx_q[$];
  initial pkt_ready = 1'b0;
  // collect taken packets, ready is the inverse of stall
  always @(posedge core_clk)
  begin
    if (pkt_valid === 1'b1 && pkt_ready === 1'b1)
      rx_q.push_back(pkt);
    pkt_ready <= #1 !stall;
  end
endmodule : ntc_host_model

/* File: tb/ntc_network_time_capture_tb_top.sv */
`timescale 1ns/1ps
module ntc_network_time_capture_tb_top;
  import ntc_pkg::*;
  localparam int D = 8;
  logic        core_clk, rst_b, time_strobe_n, board_restart_n, read_time_req;
  logic        host_serial_rx, console_serial_rx, radio_hold_off, time_set_valid;
  logic        lf_osc_running, radio_needs_ref, stall, pkt_valid, pkt_ready;
  logic        host_serial_busy, console_serial_busy, cpu_busy, capture_overrun;
  logic        cpu_reboot;
  logic [47:0] time_set_value, v, off, s0;
  logic [31:0] seed = 32'hbc1473e6;
  ntc_pkt_t    pkt, p;
  ntc_pwr_t    pwr;
  int          miscompares, num_checks, cyc, ts, ta, tb;
  ntc_network_time_capture #(.REQ_DELAY_CYC(D)) ntc_network_time_capture_inst (.*);
  ntc_host_model ntc_host_model_inst (.*);
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc++;
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed[3:0]);
  endfunction : rnd
  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic chk(string n, logic [47:0] e, logic [47:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic strobe(output int t);
    time_strobe_n = 1'b0;
    step(3);
    time_strobe_n = 1'b1;
    t = cyc;
    step(4);
  endtask : strobe
  task automatic get();
    int i;
    for (i = 0; i < 100 && ntc_host_model_inst.rx_q.size() == 0; i++)
      step(1);
    if (i == 100)
    begin
      miscompares++;
      wrap_up();
    end
    else
      p = ntc_host_model_inst.rx_q.pop_front();
  endtask : get
  initial
  begin
    {time_strobe_n, board_restart_n, host_serial_rx, console_serial_rx} = 4'hf;
    {radio_hold_off, read_time_req, time_set_valid, lf_osc_running} = 4'h0;
    {radio_needs_ref, stall, host_serial_busy, console_serial_busy, cpu_busy} = 5'h0;
    time_set_value = 48'h0;
    rst_b = 1'b0;
    step(2);
    rst_b = 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      v = {seed[15:0], seed ^ 32'h5a5a};
      time_set_value = v;
      time_set_valid = 1'b1;
      step(1);
      time_set_valid = 1'b0;
      ts = cyc;
      step(rnd() + 1);
      strobe(tb);
      get();
      if (k == 0)
        off = p.stamp - v - (tb - ts);
      chk("stamp", v + (tb - ts) + off, p.stamp);
      chk("src", NTC_SRC_STROBE, p.src);
    end
    $display("strobe test done");
    stall = 1'b1;
    strobe(ta);
    strobe(tb);
    chk("overrun", 1, capture_overrun);
    stall = 1'b0;
    get();
    chk("stamp", v + (tb - ts) + off, p.stamp);
    chk("overrun clr", 0, capture_overrun);
    step(4);
    chk("count", 0, ntc_host_model_inst.rx_q.size());
    $display("overrun test done");
    for (int k = 0; k < 2; k++)
    begin
      step(rnd() + 1);
      read_time_req = 1'b1;
      step(1);
      read_time_req = 1'b0;
      ta = cyc;
      step(2);
      read_time_req = 1'b1;
      step(1);
      read_time_req = 1'b0;
      get();
      chk("wait", 1, cyc - ta >= D);
      chk("src", NTC_SRC_REQUEST, p.src);
      if (k == 0)
        s0 = p.stamp - ta;
      chk("stamp", s0 + ta, p.stamp);
      step(D + 4);
      chk("count", 0, ntc_host_model_inst.rx_q.size());
    end
    $display("request test done");
    lf_osc_running = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      step(NTC_IDLE_CYC + 20);
      chk("doze", 3'b010, {pwr.periph_clk_en, pwr.lf_osc_en, pwr.dcdc_en});
      if (k == 1)
        console_serial_rx = 1'b0;
      else
        host_serial_rx = 1'b0;
      step(1);
      {host_serial_rx, console_serial_rx} = 2'b11;
      step(2);
      chk("wake pin", (k == 0) ? 2'b10 : 2'b01, {pwr.host_wake, pwr.console_wake});
      step(6);
      chk("wake", 3'b111, {pwr.periph_clk_en, pwr.lf_osc_en, pwr.dcdc_en});
    end
    $display("doze test done");
    radio_needs_ref = 1'b1;
    step(6);
    chk("ref", 1, pwr.ref_osc_en);
    radio_hold_off = 1'b1;
    step(6);
    chk("ref hold", 0, pwr.ref_osc_en);
    {radio_hold_off, radio_needs_ref} = 2'b00;
    $display("reference test done");
    board_restart_n = 1'b0;
    step(6);
    chk("reboot", 2'b10, {cpu_reboot, pkt_valid});
    board_restart_n = 1'b1;
    step(6);
    chk("reboot end", 0, cpu_reboot);
    $display("restart test done");
    wrap_up();
  end
endmodule : ntc_network_time_capture_tb_top
bind ntc_network_time_capture ntc_assertions #(.REQ_DELAY_CYC(REQ_DELAY_CYC))
  ntc_assertions_inst (.*);
